// file: logic/svc_pkg.sv
`default_nettype none
package svc_pkg;
   // Byte offsets of the four registers on the bus
   localparam logic [3:0] CLK_OFS = 4'h0;
   localparam logic [3:0] CTL_OFS = 4'h4;
   localparam logic [3:0] FLAG_OFS = 4'h8;
   localparam logic [3:0] IE_OFS = 4'hc;
   // Clock control fields
   localparam int CLK_DEBUG_RUN_BIT = 8;
   localparam int CLK_DIV_LSB = 4;
   localparam int CLK_SRC_LSB = 0;
   localparam logic DEBUG_RUN_RST = 1'b1;
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic [1:0] SRC_RST = 2'h0;
   // Control fields
   localparam int CTL_VOLTAGE_SOURCE_SELECT_BIT = 15;
   localparam int CTL_SC_LSB = 13;
   localparam int CTL_THR_LSB = 8;
   localparam int CTL_RE_LSB = 4;
   localparam int CTL_EXTERNAL_PIN_SELECT_BIT = 3;
   localparam int CTL_MD_LSB = 1;
   localparam int CTL_EN_BIT = 0;
   localparam logic [4:0] THR_RST = 5'h1e;
   localparam logic [3:0] RE_RESET_CODE = 4'ha;
   // Status, flag and enable fields
   localparam int STAT_LOW_BIT = 8;
   localparam int FLAG_BIT = 0;
   localparam int IE_BIT = 0;
   // Clock source codes and divider codes
   localparam logic [1:0] SRC_INTERNAL_OSCILLATOR = 2'h0;
   localparam logic [1:0] SRC_HSOSC = 2'h2;
   localparam logic [2:0] DIV_MAX_CODE = 3'h5;
   localparam logic [2:0] DIV_PASS_LO = 3'h6;
   localparam logic [8:0] DIV_BASE = 9'h010;
   localparam logic [8:0] PERIOD_BASE = 9'h080;
   // Cycles the enable change needs before it reads back
   localparam logic [3:0] EN_SETTLE_CYC = 4'h4;
   // Enable handshake states
   typedef enum logic [2:0] {
      EN_IDLE = 3'b001,
      EN_ON_WAIT = 3'b010,
      EN_OFF_WAIT = 3'b100
   } svc_en_state_t;
endpackage
`default_nettype wire

// file: logic/svc_mon_if.sv
`timescale 1ns/1ps
`default_nettype none
// Ties the control block, the monitor clock divider and the detection sequencer
interface svc_mon_if;
   logic tick; // One pulse per monitor clock period
   logic run; // Detection enabled
   logic reinit; // Restart internal detection state
   logic [1:0] mode; // Intermittent mode code
   logic [1:0] count_code; // Successive count code
   logic low_in; // Synchronised comparator output
   logic event_p; // Detection event pulse
   logic status; // Latest detection result
   modport div (output tick);
   modport seq (input tick, run, reinit, mode, count_code, low_in, output event_p, status);
   modport ctrl (input tick, event_p, status, output run, reinit, mode, count_code, low_in);
endinterface
`default_nettype wire

// file: logic/svc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// Derives the monitor clock tick from the selected source edge
module svc_clk_div (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic src_edge,
   input wire logic [1:0] src_sel,
   input wire logic [2:0] div_code,
   input wire logic halt,
   svc_mon_if.div mon
);
   logic [8:0] cnt_ff; // Division counter
   logic divided; // Source with a divider range
   logic [8:0] limit;
   assign divided = (src_sel == svc_pkg::SRC_INTERNAL_OSCILLATOR) || (src_sel == svc_pkg::SRC_HSOSC);
   assign limit = 9'((svc_pkg::DIV_BASE << div_code) - 9'h001);
   // Counter and tick; reserved combinations give no clock at all
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_ff <= 9'h000;
         mon.tick <= 1'b0;
      end else if (halt || !src_edge) begin
         // Debug stop freezes the count rather than losing it
         mon.tick <= 1'b0;
      end else if (divided) begin
         if (div_code > svc_pkg::DIV_MAX_CODE) begin
            mon.tick <= 1'b0;
         end else if (cnt_ff >= limit) begin
            cnt_ff <= 9'h000;
            mon.tick <= 1'b1;
         end else begin
            cnt_ff <= 9'(cnt_ff + 9'h001);
            mon.tick <= 1'b0;
         end
      end else begin
         mon.tick <= (div_code >= svc_pkg::DIV_PASS_LO);
      end
   end
endmodule
`default_nettype wire

// file: logic/svc_detect_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Samples the comparator continuously or intermittently and counts successive lows
module svc_detect_seq (
   input wire logic clk_sys,
   input wire logic srst,
   svc_mon_if.seq mon
);
   logic [8:0] per_ff; // Intermittent interval counter
   logic [3:0] succ_ff; // Successive low detections
   logic [8:0] per_limit;
   logic [3:0] need;
   logic sample;
   assign per_limit = 9'((svc_pkg::PERIOD_BASE << (mon.mode - 2'h1)) - 9'h001);
   assign need = 4'(4'h1 << mon.count_code);
   assign sample = mon.tick && ((mon.mode == 2'h0) || (per_ff == per_limit));
   // Interval counter
   always_ff @(posedge clk_sys) begin
      if (srst || mon.reinit || !mon.run || (mon.mode == 2'h0)) begin
         per_ff <= 9'h000;
      end else if (mon.tick) begin
         per_ff <= (per_ff == per_limit) ? 9'h000 : 9'(per_ff + 9'h001);
      end
   end
   // Result latch and event generation
   always_ff @(posedge clk_sys) begin
      if (srst || mon.reinit || !mon.run) begin
         succ_ff <= 4'h0;
         mon.event_p <= 1'b0;
         if (srst) begin
            mon.status <= 1'b0;
         end
      end else if (sample) begin
         mon.status <= mon.low_in;
         if (mon.mode == 2'h0) begin
            // Continuous mode ignores the count field
            mon.event_p <= mon.low_in;
         end else if (!mon.low_in) begin
            succ_ff <= 4'h0;
            mon.event_p <= 1'b0;
         end else if (4'(succ_ff + 4'h1) >= need) begin
            succ_ff <= 4'h0;
            mon.event_p <= 1'b1;
         end else begin
            succ_ff <= 4'(succ_ff + 4'h1);
            mon.event_p <= 1'b0;
         end
      end else begin
         mon.event_p <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: logic/svc_ctrl.sv
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Supply monitor control: registers, enable handshake, detector reset state
module svc_ctrl (
   input wire logic clk_sys,
   input wire logic srst,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // System protection open (key written), same clock domain
   input wire logic prot_unlocked,
   // Asynchronous inputs
   input wire logic internal_oscillator,
   input wire logic low_speed_oscillator,
   input wire logic high_speed_oscillator,
   input wire logic external_clock_input,
   input wire logic debug_mode,
   input wire logic comparator_low,
   // Analog front end control
   output logic comparator_enable,
   output logic sense_external,
   output logic sense_pin_sel,
   output logic [4:0] threshold_code,
   output logic monitor_clock,
   // System outputs
   output logic irq_req,
   output logic detector_reset_req
);
   // Register fields
   logic debug_run_ff;
   logic [2:0] clock_divider_ff;
   logic [1:0] clock_source_ff;
   logic voltage_source_select_ff;
   logic external_pin_select_ff;
   logic [1:0] successive_count_ff;
   logic [4:0] threshold_code_ff;
   logic [3:0] reset_select_ff;
   logic [1:0] intermittent_mode_ff;
   logic detection_enable_ff; // Readback value of the enable bit
   logic low_voltage_flag_ff;
   logic low_voltage_irq_enable_ff;
   // Detector reset state and saved mode settings
   logic rst_state_ff;
   logic [1:0] saved_mode_ff;
   logic [1:0] saved_count_ff;
   // Enable handshake
   svc_pkg::svc_en_state_t en_state_ff;
   logic [3:0] en_cnt_ff;
   logic hw_run_ff; // Detector hardware running
   logic reinit_ff;
   // Bus
   logic ack_ff;
   logic [31:0] dat_ff;
   logic irq_ff;
   // Synchronisers: first stage read only by the second
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic src_prev_ff;
   logic src_now;
   logic src_edge;
   logic tick_ff;
   // Decoded bus strobes
   logic req;
   logic wr_en;
   logic wr_clk;
   logic wr_ctl;
   logic wr_flag;
   logic wr_ie;
   logic [15:0] wr_ctl_val;
   logic [15:0] wr_clk_val;
   logic flag_clear;
   logic flag_set;
   logic rst_entry;
   logic rst_release;
   logic cfg_change;
   logic [15:0] rd_val;

   svc_mon_if mon ();

   // Merges the two low byte lanes of a write into a 16-bit register image
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] data,
                                          input logic [3:0] sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = data[7:0];
      end
      if (sel[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   // Current register images, reserved bits zero
   function automatic logic [15:0] clk_img(input logic dbr, input logic [2:0] dv, input logic [1:0] sr);
      logic [15:0] r;
      r = 16'h0000;
      r[svc_pkg::CLK_DEBUG_RUN_BIT] = dbr;
      r[svc_pkg::CLK_DIV_LSB +: 3] = dv;
      r[svc_pkg::CLK_SRC_LSB +: 2] = sr;
      return r;
   endfunction

   assign req = wb_cyc_i && wb_stb_i;
   // Writes take effect on the edge where the master sees ack
   assign wr_en = req && wb_we_i && ack_ff;
   assign wr_clk = wr_en && (wb_adr_i == svc_pkg::CLK_OFS) && prot_unlocked;
   assign wr_ctl = wr_en && (wb_adr_i == svc_pkg::CTL_OFS) && prot_unlocked;
   assign wr_flag = wr_en && (wb_adr_i == svc_pkg::FLAG_OFS);
   assign wr_ie = wr_en && (wb_adr_i == svc_pkg::IE_OFS);
   assign wr_clk_val = merge16(clk_img(debug_run_ff, clock_divider_ff, clock_source_ff), wb_dat_i, wb_sel_i);
   always_comb wr_ctl_val = merge16(rd_ctl(), wb_dat_i, wb_sel_i); // Process form so register changes re-evaluate
   assign flag_clear = wr_flag && wb_sel_i[0] && wb_dat_i[svc_pkg::FLAG_BIT];
   assign flag_set = mon.event_p;
   assign rst_entry = flag_set && (reset_select_ff == svc_pkg::RE_RESET_CODE) && !rst_state_ff;
   assign rst_release = rst_state_ff && !mon.status && !rst_entry;
   // Changing these fields while running restarts detection
   assign cfg_change = wr_ctl && hw_run_ff &&
      ((wr_ctl_val[svc_pkg::CTL_RE_LSB +: 4] != reset_select_ff) ||
       (wr_ctl_val[svc_pkg::CTL_MD_LSB +: 2] != intermittent_mode_ff) ||
       ((intermittent_mode_ff != 2'h0) &&
        (wr_ctl_val[svc_pkg::CTL_SC_LSB +: 2] != successive_count_ff)));

   // Control register image with readback of the enable bit
   function automatic logic [15:0] rd_ctl();
      logic [15:0] r;
      r = 16'h0000;
      r[svc_pkg::CTL_VOLTAGE_SOURCE_SELECT_BIT] = voltage_source_select_ff;
      r[svc_pkg::CTL_SC_LSB +: 2] = successive_count_ff;
      r[svc_pkg::CTL_THR_LSB +: 5] = threshold_code_ff;
      r[svc_pkg::CTL_RE_LSB +: 4] = reset_select_ff;
      r[svc_pkg::CTL_EXTERNAL_PIN_SELECT_BIT] = external_pin_select_ff;
      r[svc_pkg::CTL_MD_LSB +: 2] = intermittent_mode_ff;
      r[svc_pkg::CTL_EN_BIT] = detection_enable_ff;
      return r;
   endfunction

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      rd_val = 16'h0000;
      unique case (wb_adr_i)
         svc_pkg::CLK_OFS: begin
            rd_val = clk_img(debug_run_ff, clock_divider_ff, clock_source_ff);
         end
         svc_pkg::CTL_OFS: begin
            rd_val = rd_ctl();
         end
         svc_pkg::FLAG_OFS: begin
            rd_val[svc_pkg::STAT_LOW_BIT] = mon.status;
            rd_val[svc_pkg::FLAG_BIT] = low_voltage_flag_ff;
         end
         svc_pkg::IE_OFS: begin
            rd_val[svc_pkg::IE_BIT] = low_voltage_irq_enable_ff;
         end
         default: begin
            rd_val = 16'h0000;
         end
      endcase
   end

   // Bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req && !ack_ff;
         if (req && !ack_ff) begin
            dat_ff <= {16'h0000, rd_val};
         end
      end
   end

   // Two-flop synchronisers for clocks, debug state and comparator
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
         src_prev_ff <= 1'b0;
      end else begin
         sync1_ff <= {comparator_low, debug_mode, external_clock_input, high_speed_oscillator,
                      low_speed_oscillator, internal_oscillator};
         sync2_ff <= sync1_ff;
         src_prev_ff <= src_now;
      end
   end
   assign src_now = sync2_ff[clock_source_ff];
   assign src_edge = src_now && !src_prev_ff;

   // Clock control register; forced to initial values in detector reset
   always_ff @(posedge clk_sys) begin
      if (srst || rst_state_ff) begin
         debug_run_ff <= svc_pkg::DEBUG_RUN_RST;
         clock_divider_ff <= svc_pkg::DIV_RST;
         clock_source_ff <= svc_pkg::SRC_RST;
      end else if (wr_clk) begin
         debug_run_ff <= wr_clk_val[svc_pkg::CLK_DEBUG_RUN_BIT];
         clock_divider_ff <= wr_clk_val[svc_pkg::CLK_DIV_LSB +: 3];
         clock_source_ff <= wr_clk_val[svc_pkg::CLK_SRC_LSB +: 2];
      end
   end

   // Plain control fields, kept through the detector reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         voltage_source_select_ff <= 1'b0;
         external_pin_select_ff <= 1'b0;
         threshold_code_ff <= svc_pkg::THR_RST;
         reset_select_ff <= 4'h0;
      end else if (wr_ctl && !rst_state_ff) begin
         voltage_source_select_ff <= wr_ctl_val[svc_pkg::CTL_VOLTAGE_SOURCE_SELECT_BIT];
         external_pin_select_ff <= wr_ctl_val[svc_pkg::CTL_EXTERNAL_PIN_SELECT_BIT];
         threshold_code_ff <= wr_ctl_val[svc_pkg::CTL_THR_LSB +: 5];
         reset_select_ff <= wr_ctl_val[svc_pkg::CTL_RE_LSB +: 4];
      end
   end
   // Writes during the detector reset are dropped so the kept values stay put

   // Mode and count fields, saved on entry to the detector reset and restored on release
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         intermittent_mode_ff <= 2'h0;
         successive_count_ff <= 2'h0;
         saved_mode_ff <= 2'h0;
         saved_count_ff <= 2'h0;
      end else if (rst_entry) begin
         saved_mode_ff <= intermittent_mode_ff;
         saved_count_ff <= successive_count_ff;
         intermittent_mode_ff <= 2'h0;
         successive_count_ff <= 2'h0;
      end else if (rst_release) begin
         intermittent_mode_ff <= saved_mode_ff;
         successive_count_ff <= saved_count_ff;
      end else if (wr_ctl && !rst_state_ff) begin
         intermittent_mode_ff <= wr_ctl_val[svc_pkg::CTL_MD_LSB +: 2];
         if (intermittent_mode_ff != 2'h0) begin
            successive_count_ff <= wr_ctl_val[svc_pkg::CTL_SC_LSB +: 2];
         end
      end
   end

   // Enable handshake: readback changes only after the hardware settles
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         en_state_ff <= svc_pkg::EN_IDLE;
         en_cnt_ff <= 4'h0;
         detection_enable_ff <= 1'b0;
         hw_run_ff <= 1'b0;
      end else begin
         unique case (en_state_ff)
            svc_pkg::EN_IDLE: begin
               en_cnt_ff <= 4'h0;
               // The enable stays 1 through the detector reset
               if (wr_ctl && !rst_state_ff && (wr_ctl_val[svc_pkg::CTL_EN_BIT] != detection_enable_ff)) begin
                  if (wr_ctl_val[svc_pkg::CTL_EN_BIT]) begin
                     hw_run_ff <= 1'b1;
                     en_state_ff <= svc_pkg::EN_ON_WAIT;
                  end else begin
                     hw_run_ff <= 1'b0;
                     en_state_ff <= svc_pkg::EN_OFF_WAIT;
                  end
               end
            end
            svc_pkg::EN_ON_WAIT, svc_pkg::EN_OFF_WAIT: begin
               // Enable writes here are ignored; software polls first
               if (en_cnt_ff == 4'(svc_pkg::EN_SETTLE_CYC - 4'h1)) begin
                  detection_enable_ff <= hw_run_ff;
                  en_state_ff <= svc_pkg::EN_IDLE;
               end else begin
                  en_cnt_ff <= 4'(en_cnt_ff + 4'h1);
               end
            end
            default: begin
               en_state_ff <= svc_pkg::EN_IDLE;
            end
         endcase
      end
   end

   // Restart pulse for the sequencer
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reinit_ff <= 1'b1;
      end else begin
         reinit_ff <= cfg_change || (flag_clear && hw_run_ff) || rst_entry || rst_release ||
                      (en_state_ff == svc_pkg::EN_OFF_WAIT);
      end
   end

   // Interrupt flag: a detection in the clearing cycle wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         low_voltage_flag_ff <= 1'b0;
      end else if (flag_set) begin
         low_voltage_flag_ff <= 1'b1;
      end else if (flag_clear) begin
         low_voltage_flag_ff <= 1'b0;
      end
   end

   // Interrupt enable, cleared while the detector reset stands
   always_ff @(posedge clk_sys) begin
      if (srst || rst_state_ff || rst_entry) begin
         low_voltage_irq_enable_ff <= 1'b0;
      end else if (wr_ie && wb_sel_i[0]) begin
         low_voltage_irq_enable_ff <= wb_dat_i[svc_pkg::IE_BIT];
      end
   end

   // Detector reset state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rst_state_ff <= 1'b0;
      end else if (rst_entry) begin
         rst_state_ff <= 1'b1;
      end else if (rst_release) begin
         rst_state_ff <= 1'b0;
      end
   end

   // Interrupt request from registered flag and enable
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         irq_ff <= low_voltage_flag_ff && low_voltage_irq_enable_ff;
         tick_ff <= mon.tick;
      end
   end

   // Sequencer connections
   assign mon.run = hw_run_ff;
   assign mon.reinit = reinit_ff;
   assign mon.mode = intermittent_mode_ff;
   assign mon.count_code = successive_count_ff;
   assign mon.low_in = sync2_ff[5];

   svc_clk_div u_div (
      .clk_sys(clk_sys),
      .srst(srst),
      .src_edge(src_edge),
      .src_sel(clock_source_ff),
      .div_code(clock_divider_ff),
      .halt(sync2_ff[4] && !debug_run_ff),
      .mon(mon)
   );

   svc_detect_seq u_seq (
      .clk_sys(clk_sys),
      .srst(srst),
      .mon(mon)
   );

   // Outputs straight from flip-flops
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign comparator_enable = hw_run_ff;
   assign sense_external = voltage_source_select_ff;
   assign sense_pin_sel = external_pin_select_ff;
   assign threshold_code = threshold_code_ff;
   assign monitor_clock = tick_ff;
   assign irq_req = irq_ff;
   assign detector_reset_req = rst_state_ff;
endmodule
`default_nettype wire

// file: tb/svc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Ties register writes and the detector reset state to the pins that follow them
module svc_ctrl_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic prot_unlocked,
   input wire logic comparator_enable,
   input wire logic sense_external,
   input wire logic sense_pin_sel,
   input wire logic [4:0] threshold_code,
   input wire logic irq_req,
   input wire logic detector_reset_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic ctl_wr; // Control write requested at this edge, upper lane on; taken at the next edge
   logic [15:0] ctl_ff; // Data of the last control write
   assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == svc_pkg::CTL_OFS && wb_sel_i[1];
   // Keeps write data, since the master may change it once acked
   always_ff @(posedge clk_sys) begin
      if (ctl_wr) begin
         ctl_ff <= wb_dat_i[15:0];
      end
   end
   lock_hold_a: assert property (ctl_wr && !prot_unlocked |=> $stable(threshold_code) [*2])
      else $error("locked write moved threshold");
   thr_write_a: assert property (ctl_wr && prot_unlocked && !detector_reset_req
      |-> ##[2:3] threshold_code == ctl_ff[12:8])
      else $error("threshold not written");
   src_write_a: assert property (ctl_wr && prot_unlocked && !detector_reset_req
      |-> ##[2:3] {sense_external, sense_pin_sel} == {ctl_ff[15], ctl_ff[3]})
      else $error("source select not written");
   rst_keep_a: assert property ($rose(detector_reset_req)
      |-> $stable(threshold_code) && $stable(sense_external))
      else $error("setting lost at reset");
   rst_enable_a: assert property (detector_reset_req |-> comparator_enable)
      else $error("detector stopped in reset");
   rst_irq_a: assert property (detector_reset_req [*3] |-> !irq_req)
      else $error("irq during reset state");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   en_cause_a: assert property ($rose(comparator_enable) |-> $past(wb_ack_o) && $past(wb_we_i))
      else $error("enable rose without write");
endmodule
`default_nettype wire

// file: tb/svc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module svc_ctrl_tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic prot = 1'b0; // Protection key open
   logic lo = 1'b0; // Comparator says supply is low
   logic osc = 1'b0; // Slow source shared by two clock inputs
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, en, sx, sp, irq, drst, mclk;
   logic dbg = 1'b0; // CPU sits in debug
   int ticks = 0; // Monitor clock pulses seen so far
   int t0; // Pulse count at the start of a window
   logic [4:0] thr;
   int miscompares = 0;
   int samples_checked = 0;
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // Source edges every two cycles, so one tick per edge when undivided
   always @(posedge clk_sys) osc <= ~osc;
   // Counts monitor clock pulses for the debug stop checks
   always @(posedge clk_sys) if (mclk === 1'b1) ticks <= ticks + 1;
   svc_ctrl u_svc_ctrl (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .prot_unlocked(prot), .internal_oscillator(osc), .low_speed_oscillator(osc),
      .high_speed_oscillator(1'b0), .external_clock_input(1'b0), .debug_mode(dbg),
      .comparator_low(lo), .comparator_enable(en), .sense_external(sx), .sense_pin_sel(sp),
      .threshold_code(thr), .monitor_clock(mclk), .irq_req(irq), .detector_reset_req(drst));
   // One classic cycle; the request stands until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // A missing answer counts against the run
      if (ack !== 1'b1) begin
         miscompares++;
         $display("mismatch ack exp 1 got %b", ack);
      end
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(nm, q, e);
   endtask
   // Reads until the value shows; a slow settle is not a fault
   task automatic poll(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      for (int i = 0; i < 40; i++) begin
         bus(1'b0, a, 32'h0000_0000, q);
         if (q === e) break;
      end
      chk("poll", q, e);
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int n = 0; n < 20000 && s !== v; n++) @(posedge clk_sys);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rd(svc_pkg::CLK_OFS, 32'h0000_0100, "clk");
      rd(svc_pkg::CTL_OFS, 32'h0000_1e00, "ctl");
      rd(svc_pkg::IE_OFS, 32'h0000_0000, "ie");
      rd(4'h2, 32'h0000_0000, "hole");
      wr(svc_pkg::CTL_OFS, 32'h0000_ffff);
      rd(svc_pkg::CTL_OFS, 32'h0000_1e00, "locked");
      prot <= 1'b1;
      wr(svc_pkg::CLK_OFS, 32'h0000_ffed);
      rd(svc_pkg::CLK_OFS, 32'h0000_0161, "clkw");
      // Debug with the run bit set keeps the clock; cleared, it stops
      dbg <= 1'b1;
      repeat (8) @(posedge clk_sys);
      t0 = ticks;
      repeat (20) @(posedge clk_sys);
      chk("dbgrun", 32'(ticks != t0), 32'h0000_0001);
      wr(svc_pkg::CLK_OFS, 32'h0000_0061);
      repeat (4) @(posedge clk_sys);
      t0 = ticks;
      repeat (20) @(posedge clk_sys);
      chk("dbgstop", 32'(ticks - t0), 32'h0000_0000);
      dbg <= 1'b0;
      wr(svc_pkg::CTL_OFS, 32'h0000_e508);
      rd(svc_pkg::CTL_OFS, 32'h0000_8508, "sc0");
      chk("pins", 32'({sx, sp, thr}), 32'h0000_0065);
      wr(svc_pkg::CTL_OFS, 32'h0000_8509);
      rd(svc_pkg::CTL_OFS, 32'h0000_8508, "settle");
      poll(svc_pkg::CTL_OFS, 32'h0000_8509);
      chk("en", 32'(en), 32'h0000_0001);
      wr(svc_pkg::IE_OFS, 32'h0000_0001);
      lo <= 1'b1;
      wait_for(irq, 1'b1);
      chk("irq", 32'(irq), 32'h0000_0001);
      wr(svc_pkg::FLAG_OFS, 32'h0000_0000);
      rd(svc_pkg::FLAG_OFS, 32'h0000_0101, "flag");
      lo <= 1'b0;
      poll(svc_pkg::FLAG_OFS, 32'h0000_0001);
      wr(svc_pkg::FLAG_OFS, 32'h0000_0001);
      rd(svc_pkg::FLAG_OFS, 32'h0000_0000, "w1c");
      chk("irq0", 32'(irq), 32'h0000_0000);
      wr(svc_pkg::CTL_OFS, 32'h0000_85a3);
      wr(svc_pkg::CTL_OFS, 32'h0000_c5a3);
      rd(svc_pkg::CTL_OFS, 32'h0000_c5a3, "sc");
      lo <= 1'b1;
      wait_for(drst, 1'b1);
      chk("drst", 32'(drst), 32'h0000_0001);
      rd(svc_pkg::CTL_OFS, 32'h0000_85a1, "rctl");
      rd(svc_pkg::CLK_OFS, 32'h0000_0100, "rclk");
      rd(svc_pkg::IE_OFS, 32'h0000_0000, "rie");
      rd(svc_pkg::FLAG_OFS, 32'h0000_0101, "rflag");
      lo <= 1'b0;
      wait_for(drst, 1'b0);
      chk("drst0", 32'(drst), 32'h0000_0000);
      rd(svc_pkg::CTL_OFS, 32'h0000_c5a3, "back");
      give_verdict;
   end
   // Cuts a hang short well past the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys);
      miscompares++;
      give_verdict;
   end
endmodule
bind svc_ctrl svc_ctrl_chk u_svc_ctrl_chk (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prot_unlocked(prot_unlocked),
   .comparator_enable(comparator_enable), .sense_external(sense_external), .sense_pin_sel(sense_pin_sel),
   .threshold_code(threshold_code), .irq_req(irq_req), .detector_reset_req(detector_reset_req));
`default_nettype wire
